// ===== rtl/slave_cpu_interrupt_host_port.sv
// Interrupt, event counter, host signalling and host buffer logic of a
// slave microcomputer. Assumes the core sequencer drives one op per
// instruction on OP_IN with INSTR_DONE_IN pulsing at instruction end.
`timescale 1ns/100ps
`include "slave_irq_map.svh"
module slave_cpu_interrupt_host_port #(
	parameter int PC_W = 12,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	// Core sequencer
	input wire slave_irq_pkg::core_op_t OP_IN,
	input wire logic INSTR_DONE_IN,
	input wire logic [7:0] ACC_IN,
	input wire logic [PC_W-1:0] PC_IN,
	input wire logic [3:0] PSW_HI_IN,
	input wire logic [PC_W-1:0] STACK_PC_IN,
	input wire logic [3:0] STACK_PSW_IN,
	input wire logic PORT2_WRITE_IN,
	input wire logic TIMER_TICK_IN,
	// Core results
	output logic CALL_OUT,
	output logic [PC_W-1:0] VECTOR_OUT,
	output logic [PC_W-1:0] PUSH_PC_OUT,
	output logic [3:0] PUSH_PSW_OUT,
	output logic SP_INC_OUT,
	output logic SP_DEC_OUT,
	output logic [PC_W-1:0] RESTORE_PC_OUT,
	output logic [3:0] RESTORE_PSW_OUT,
	output logic RESTORE_OUT,
	output logic [7:0] INBUF_DATA_OUT,
	output logic INBUF_VALID_OUT,
	output logic [7:0] COUNT_OUT,
	output logic SENSE0_OUT,
	output logic SENSE1_OUT,
	// Sense pins
	input wire logic SENSE0_IN,
	input wire logic SENSE1_IN,
	// Port 2 upper pins
	input wire logic [7:4] PORT2_IN,
	output logic [7:4] PORT2_OUT,
	output logic [7:4] PORT2_OE_N_OUT,
	// Host bus
	input wire slave_irq_pkg::host_ctl_t HOST_CTL_IN,
	input wire logic [7:0] HOST_D_IN,
	output logic [7:0] HOST_D_OUT,
	output logic HOST_D_OE_N_OUT,
	output logic HOST_WREADY_OUT
);
	import slave_irq_pkg::*;

	// Reset synchronizer
	logic rst_s1;
	logic rst_s2;
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	wire nrst = rst_s2;

	// Host control synchronizers, ack folded in as select
	logic [3:0] hs1;
	logic [3:0] hs2;
	logic [3:0] hs3;
	logic transfer_ack_pin_sel;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			hs1 <= 4'hE;
			hs2 <= 4'hE;
			hs3 <= 4'hE;
		end
		else
		begin
			hs1 <= {HOST_CTL_IN.cs_n && !transfer_ack_pin_sel, HOST_CTL_IN.rd_n,
				HOST_CTL_IN.wr_n, HOST_CTL_IN.a0};
			hs2 <= hs1;
			hs3 <= hs2;
		end
	end
	wire sel = !hs2[3];
	wire wr_act = sel && !hs2[1];
	wire rd_act = sel && !hs2[2] && hs2[1];
	wire wr_rise = wr_act && !(!hs3[3] && !hs3[1]);
	wire rd_fall = !(rd_act) && (!hs3[3] && !hs3[2] && hs3[1]);
	logic [7:0] host_d_q;
	always_ff @(posedge CORE_CLK_IN)
		host_d_q <= HOST_D_IN;

	// Input buffer path through FIFO
	logic fifo_rvalid;
	host_word_t fifo_rdata;
	host_word_t fifo_wdata;
	assign fifo_wdata = '{data: host_d_q, cmd: hs2[0]};
	slave_irq_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(CORE_CLK_IN),
		.nrst_in(nrst),
		.wdata_in(fifo_wdata),
		.wvalid_in(wr_rise),
		.wready_out(HOST_WREADY_OUT),
		.rdata_out(fifo_rdata),
		.rvalid_out(fifo_rvalid),
		.rready_in(OP_IN == OP_READ_INBUF)
	);
	wire input_full_flag = fifo_rvalid;

	// Output buffer, flags, status
	logic [7:0] host_output_buffer;
	logic output_full_flag;
	logic cmd_data_flag;
	logic [3:0] user_status;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			host_output_buffer <= 8'h00;
			output_full_flag <= 1'b0;
			cmd_data_flag <= 1'b0;
			user_status <= 4'h0;
			INBUF_DATA_OUT <= 8'h00;
			INBUF_VALID_OUT <= 1'b0;
		end
		else
		begin
			INBUF_VALID_OUT <= (OP_IN == OP_READ_INBUF) && fifo_rvalid;
			if (OP_IN == OP_READ_INBUF)
				INBUF_DATA_OUT <= fifo_rdata.data;
			if (OP_IN == OP_WRITE_OUTBUF)
				host_output_buffer <= ACC_IN;
			if (OP_IN == OP_SET_STATUS)
				user_status <= ACC_IN[7:4];
			if (OP_IN == OP_WRITE_OUTBUF)
				output_full_flag <= 1'b1;
			else if (rd_fall && !hs3[0])
				output_full_flag <= 1'b0;
			if (wr_rise)
				cmd_data_flag <= hs2[0];
		end
	end
	wire [7:0] status_word = {user_status, cmd_data_flag, 1'b0,
		input_full_flag, output_full_flag};
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			HOST_D_OUT <= 8'h00;
			HOST_D_OE_N_OUT <= 1'b1;
		end
		else
		begin
			HOST_D_OE_N_OUT <= !rd_act;
			HOST_D_OUT <= hs2[0] ? status_word : host_output_buffer;
		end
	end

	// Sense pins and event counter
	logic count_mode;
	logic sense_high_seen;
	logic [7:0] counter;
	logic overflow_req;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			count_mode <= 1'b0;
			SENSE0_OUT <= 1'b0;
			SENSE1_OUT <= 1'b0;
		end
		else
		begin
			if (OP_IN == OP_BEGIN_COUNT)
				count_mode <= 1'b1;
			else if (OP_IN == OP_HALT_COUNT)
				count_mode <= 1'b0;
			SENSE0_OUT <= SENSE0_IN;
			SENSE1_OUT <= SENSE1_IN;
		end
	end
	wire count_step = count_mode && INSTR_DONE_IN && sense_high_seen
		&& !SENSE1_IN;
	wire timer_step = TIMER_TICK_IN && !count_mode;
	wire inc = count_step || timer_step;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			sense_high_seen <= 1'b0;
			counter <= 8'h00;
		end
		else
		begin
			if (count_mode && INSTR_DONE_IN)
				sense_high_seen <= SENSE1_IN;
			if (OP_IN == OP_LOAD_COUNT)
				counter <= ACC_IN;
			else if (inc)
				counter <= counter + 8'h01;
		end
	end
	assign COUNT_OUT = counter;

	// Interrupt control
	logic buf_irq_en;
	logic ovf_irq_en;
	logic buf_req;
	logic in_service;
	irq_state_t state;
	logic [2:0] lat_cnt;
	logic take_buf;
	logic take_ovf;
	wire ovf_event = inc && (counter == `COUNT_MAX);
	wire accept_ok = (state == ST_RUN) && INSTR_DONE_IN && !in_service;
	assign take_buf = accept_ok && buf_irq_en && buf_req;
	assign take_ovf = accept_ok && ovf_irq_en && overflow_req && !take_buf;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_irq_en <= 1'b0;
			ovf_irq_en <= 1'b0;
		end
		else
		begin
			if (OP_IN == OP_BUF_IRQ_ON)
				buf_irq_en <= 1'b1;
			else if (OP_IN == OP_BUF_IRQ_OFF)
				buf_irq_en <= 1'b0;
			if (OP_IN == OP_OVF_IRQ_ON)
				ovf_irq_en <= 1'b1;
			else if (OP_IN == OP_OVF_IRQ_OFF)
				ovf_irq_en <= 1'b0;
		end
	end
	// Set wins over clear when both occur in one cycle
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_req <= 1'b0;
			overflow_req <= 1'b0;
		end
		else
		begin
			if (wr_act)
				buf_req <= 1'b1;
			else if (take_buf)
				buf_req <= 1'b0;
			if (ovf_event)
				overflow_req <= 1'b1;
			else if (take_ovf)
				overflow_req <= 1'b0;
		end
	end
	// Vector call spread over a fixed entry delay inside the latency window
	logic pend_vec;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= ST_RUN;
			in_service <= 1'b0;
			lat_cnt <= 3'h0;
			pend_vec <= 1'b0;
		end
		else
		begin
			unique case (state)
				ST_RUN:
					if (take_buf || take_ovf)
					begin
						state <= ST_WAIT;
						in_service <= 1'b1;
						pend_vec <= take_ovf;
						lat_cnt <= 3'(`LAT_MIN_CYC - 2);
					end
					else if (OP_IN == OP_RETURN_RESTORE)
						state <= ST_RET2;
				ST_WAIT:
					if (lat_cnt == 3'h0)
						state <= ST_SERVICE;
					else
						lat_cnt <= lat_cnt - 3'h1;
				ST_SERVICE:
					if (OP_IN == OP_RETURN_RESTORE)
						state <= ST_RET2;
				ST_RET2:
				begin
					in_service <= 1'b0;
					state <= ST_RUN;
				end
			endcase
		end
	end
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			CALL_OUT <= 1'b0;
			VECTOR_OUT <= '0;
			PUSH_PC_OUT <= '0;
			PUSH_PSW_OUT <= 4'h0;
			SP_INC_OUT <= 1'b0;
			SP_DEC_OUT <= 1'b0;
			RESTORE_OUT <= 1'b0;
			RESTORE_PC_OUT <= '0;
			RESTORE_PSW_OUT <= 4'h0;
		end
		else
		begin
			CALL_OUT <= (state == ST_WAIT) && (lat_cnt == 3'h0);
			SP_INC_OUT <= (state == ST_WAIT) && (lat_cnt == 3'h0);
			if (take_buf || take_ovf)
			begin
				PUSH_PC_OUT <= PC_IN;
				PUSH_PSW_OUT <= PSW_HI_IN;
				VECTOR_OUT <= take_ovf ? PC_W'(`OVF_VECTOR)
					: PC_W'(`BUF_VECTOR);
			end
			RESTORE_OUT <= (OP_IN == OP_RETURN_RESTORE);
			SP_DEC_OUT <= (OP_IN == OP_RETURN_RESTORE);
			if (OP_IN == OP_RETURN_RESTORE)
			begin
				RESTORE_PC_OUT <= STACK_PC_IN;
				RESTORE_PSW_OUT <= STACK_PSW_IN;
			end
		end
	end

	// Port 2 upper bits: host flags and transfer handshake
	logic host_flags_on;
	logic xfer_on;
	logic [7:4] p2_latch;
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			host_flags_on <= 1'b0;
			xfer_on <= 1'b0;
			p2_latch <= 4'hF;
		end
		else
		begin
			if (OP_IN == OP_HOST_FLAGS)
				host_flags_on <= 1'b1;
			if (OP_IN == OP_XFER_HS)
				xfer_on <= 1'b1;
			if (PORT2_WRITE_IN)
				p2_latch <= ACC_IN[7:4];
		end
	end
	assign transfer_ack_pin_sel = xfer_on && !PORT2_IN[7];
	logic [7:4] p2_val;
	always_comb
	begin
		p2_val = p2_latch;
		if (host_flags_on)
		begin
			p2_val[4] = p2_latch[4] && output_full_flag;
			p2_val[5] = p2_latch[5] && !input_full_flag;
		end
		if (xfer_on)
			p2_val[7] = 1'b1;
	end
	// Quasi-bidirectional: drive low only, release for a one
	always_ff @(posedge CORE_CLK_IN or negedge nrst)
	begin
		if (!nrst)
		begin
			PORT2_OUT <= 4'h0;
			PORT2_OE_N_OUT <= 4'hF;
		end
		else
		begin
			PORT2_OUT <= 4'h0;
			PORT2_OE_N_OUT <= p2_val;
		end
	end
endmodule : slave_cpu_interrupt_host_port

// ===== rtl/slave_irq_map.svh
// Constants for the slave interrupt and host port block.
// Assumes inclusion by the top module only.
`ifndef SLAVE_IRQ_MAP_SVH
`define SLAVE_IRQ_MAP_SVH
`define BUF_VECTOR 12'h003
`define OVF_VECTOR 12'h007
`define COUNT_MAX 8'hFF
`define LAT_MIN_CYC 4
`define LAT_MAX_CYC 7
`define STS_OBF_BIT 0
`define STS_IBF_BIT 1
`define STS_F0_BIT 2
`define STS_F1_BIT 3
`define FIFO_DEPTH 16
`endif

// ===== rtl/slave_irq_pkg.sv
// Types for the slave interrupt and host port block.
// Assumes the map header supplies all numeric constants.
package slave_irq_pkg;
	typedef enum logic [3:0] {
		OP_NONE, OP_BEGIN_COUNT, OP_HALT_COUNT, OP_BUF_IRQ_ON,
		OP_BUF_IRQ_OFF, OP_OVF_IRQ_ON, OP_OVF_IRQ_OFF, OP_RETURN_RESTORE,
		OP_HOST_FLAGS, OP_XFER_HS, OP_READ_INBUF, OP_WRITE_OUTBUF,
		OP_LOAD_COUNT, OP_SET_STATUS
	} core_op_t;
	typedef struct packed {
		logic [7:0] data;
		logic cmd;
	} host_word_t;
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic a0;
	} host_ctl_t;
	typedef enum logic [1:0] {
		ST_RUN, ST_WAIT, ST_SERVICE, ST_RET2
	} irq_state_t;
endpackage : slave_irq_pkg

// ===== rtl/slave_irq_fifo.sv
// Small synchronous FIFO used between host write port and core.
// Assumes single clock; pushes when full and pops when empty are ignored.
`timescale 1ns/100ps
module slave_irq_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Fill side
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic wvalid_in,
	output logic wready_out,
	// Drain side
	output logic [WIDTH-1:0] rdata_out,
	output logic rvalid_out,
	input wire logic rready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;
	assign wready_out = (count != (AW+1)'(DEPTH));
	assign rvalid_out = (count != '0);
	assign do_push = wvalid_in && wready_out;
	assign do_pop = rready_in && rvalid_out;
	assign rdata_out = mem[rptr];
	always_ff @(posedge clk_in)
	begin
		if (do_push)
			mem[wptr] <= wdata_in;
	end
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			if (do_push)
				wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(1);
			if (do_pop)
				rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(1);
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : slave_irq_fifo

// ===== dv/slave_irq_monitor.sv
// Port assertions for the slave interrupt and host port block.
// Assumes one clock domain and the designer's fixed call latency.
`timescale 1ns/100ps
module slave_irq_checker #(
	parameter int PC_W = 12,
	parameter int FIFO_DEPTH = 16
) (
	// Clock, reset and inputs
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire slave_irq_pkg::core_op_t OP_IN,
	input wire logic INSTR_DONE_IN,
	input wire logic [PC_W-1:0] STACK_PC_IN,
	input wire slave_irq_pkg::host_ctl_t HOST_CTL_IN,
	// Outputs
	input wire logic CALL_OUT,
	input wire logic [PC_W-1:0] VECTOR_OUT,
	input wire logic SP_INC_OUT,
	input wire logic SP_DEC_OUT,
	input wire logic RESTORE_OUT,
	input wire logic [PC_W-1:0] RESTORE_PC_OUT,
	input wire logic HOST_D_OE_N_OUT
);
	import slave_irq_pkg::*;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	a_vector_pick:
		assert property (CALL_OUT |->
			(VECTOR_OUT == 12'h003 || VECTOR_OUT == 12'h007))
		else $error("call to unknown vector");
	a_call_push:
		assert property (CALL_OUT == SP_INC_OUT)
		else $error("stack push not paired with call");
	a_call_latency:
		assert property ($rose(CALL_OUT) |-> $past(INSTR_DONE_IN, 4))
		else $error("call not four cycles after instruction end");
	a_single_level:
		assert property (CALL_OUT |=> !CALL_OUT [*4])
		else $error("nested call during service");
	a_return_pulse:
		assert property (OP_IN == OP_RETURN_RESTORE |=>
			RESTORE_OUT && SP_DEC_OUT)
		else $error("return did not restore");
	a_return_pc:
		assert property (RESTORE_OUT |->
			RESTORE_PC_OUT == $past(STACK_PC_IN))
		else $error("restored address wrong");
	a_port_idle:
		assert property (HOST_CTL_IN.cs_n [*4] |-> HOST_D_OE_N_OUT)
		else $error("data bus driven while deselected");
	a_read_drives:
		assert property ((!HOST_CTL_IN.cs_n && !HOST_CTL_IN.rd_n) [*4]
			|-> !HOST_D_OE_N_OUT)
		else $error("data bus not driven in read");
endmodule : slave_irq_checker

bind slave_cpu_interrupt_host_port slave_irq_checker #(
	.PC_W(PC_W),
	.FIFO_DEPTH(FIFO_DEPTH)
) i_slave_irq_checker (
	.CORE_CLK_IN(CORE_CLK_IN),
	.NRST_IN(NRST_IN),
	.OP_IN(OP_IN),
	.INSTR_DONE_IN(INSTR_DONE_IN),
	.STACK_PC_IN(STACK_PC_IN),
	.HOST_CTL_IN(HOST_CTL_IN),
	.CALL_OUT(CALL_OUT),
	.VECTOR_OUT(VECTOR_OUT),
	.SP_INC_OUT(SP_INC_OUT),
	.SP_DEC_OUT(SP_DEC_OUT),
	.RESTORE_OUT(RESTORE_OUT),
	.RESTORE_PC_OUT(RESTORE_PC_OUT),
	.HOST_D_OE_N_OUT(HOST_D_OE_N_OUT)
);

// ===== dv/host_master_model.sv
// Master processor model driving the host strobes and data bus.
// Assumes the bench calls access from one process at a time.
`timescale 1ns/100ps
module host_master_model (
	// Clock
	input wire logic clk_in,
	// Host bus
	output slave_irq_pkg::host_ctl_t ctl_out,
	output logic [7:0] d_out,
	input wire logic [7:0] d_in,
	// Transfer acknowledge from the transfer controller
	output logic ack_n_out
);
	import slave_irq_pkg::*;
	initial
	begin
		ctl_out = 4'hF;
		d_out = 8'h00;
		ack_n_out = 1'b1;
	end
	// Strobes held four edges so the synchronised decode sees them
	task automatic access(input logic w, input logic a0,
		input logic [7:0] wd, output logic [7:0] q);
		@(posedge clk_in);
		ctl_out <= {1'b0, w, !w, a0};
		d_out <= wd;
		repeat (4) @(posedge clk_in);
		q = d_in;
		ctl_out <= 4'hF;
		// Released bus must not look like the last byte
		d_out <= ~wd;
		repeat (3) @(posedge clk_in);
	endtask : access
	// Transfer controller write: acknowledge stands in for chip select
	task automatic dma_write(input logic [7:0] wd);
		@(posedge clk_in);
		ack_n_out <= 1'b0;
		ctl_out <= 4'hC;
		d_out <= wd;
		repeat (4) @(posedge clk_in);
		ack_n_out <= 1'b1;
		ctl_out <= 4'hF;
		d_out <= ~wd;
		repeat (3) @(posedge clk_in);
	endtask : dma_write
endmodule : host_master_model

// ===== dv/slave_cpu_interrupt_host_port_test.sv
// Self-checking bench for the slave interrupt and host port block.
// Assumes the host model for bus cycles and one core op per cycle.
`timescale 1ns/100ps
module slave_cpu_interrupt_host_port_test;
	import slave_irq_pkg::*;
	typedef struct packed {
		logic a0;
		logic [7:0] d;
		logic [7:0] st;
	} row_t;
	row_t rows [4] = '{'{1'b0, 8'h00, 8'h02}, '{1'b1, 8'hFF, 8'h0A},
		'{1'b0, 8'hA5, 8'h02}, '{1'b1, 8'h5A, 8'h0A}};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	core_op_t op = OP_NONE;
	logic done = 1'b0;
	logic [7:0] acc = 8'h00;
	logic p2w = 1'b0;
	logic s0 = 1'b0;
	logic s1 = 1'b0;
	host_ctl_t ctl;
	logic [7:0] hd, hq, rd, cnt, ib;
	logic [11:0] vec, ppc, rpc;
	logic [3:0] ppsw, rpsw, p2o, p2oe;
	logic call, spi, spd, rst, ibv, s0o, s1o, hoe, wrdy;
	logic transfer_ack_pin_n;
	int error_cnt = 0;
	int comparisons = 0;
	always #5 clk = ~clk;
	// Every other cycle ends an instruction
	always @(posedge clk) done <= ~done;
	slave_cpu_interrupt_host_port i_slave_cpu_interrupt_host_port (
		.CORE_CLK_IN(clk), .NRST_IN(nrst), .OP_IN(op),
		.INSTR_DONE_IN(done), .ACC_IN(acc), .PC_IN(12'h123),
		.PSW_HI_IN(4'hA), .STACK_PC_IN(12'h456), .STACK_PSW_IN(4'h5),
		.PORT2_WRITE_IN(p2w), .TIMER_TICK_IN(1'b0), .CALL_OUT(call),
		.VECTOR_OUT(vec), .PUSH_PC_OUT(ppc), .PUSH_PSW_OUT(ppsw),
		.SP_INC_OUT(spi), .SP_DEC_OUT(spd), .RESTORE_PC_OUT(rpc),
		.RESTORE_PSW_OUT(rpsw), .RESTORE_OUT(rst), .INBUF_DATA_OUT(ib),
		.INBUF_VALID_OUT(ibv), .COUNT_OUT(cnt), .SENSE0_OUT(s0o),
		.SENSE1_OUT(s1o), .SENSE0_IN(s0), .SENSE1_IN(s1),
		.PORT2_IN({p2oe[7] & transfer_ack_pin_n, p2oe[6:4]}), .PORT2_OUT(p2o),
		.PORT2_OE_N_OUT(p2oe),
		.HOST_CTL_IN(ctl), .HOST_D_IN(hd), .HOST_D_OUT(hq),
		.HOST_D_OE_N_OUT(hoe), .HOST_WREADY_OUT(wrdy));
	host_master_model i_host_master_model (
		.clk_in(clk), .ctl_out(ctl), .d_out(hd), .d_in(hq),
		.ack_n_out(transfer_ack_pin_n));
	task automatic report_and_stop;
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic do_op(input core_op_t o, input logic [7:0] a);
		@(posedge clk);
		op <= o;
		acc <= a;
		@(posedge clk);
		op <= OP_NONE;
	endtask : do_op
	task automatic hw(input logic w, input logic a0, input logic [7:0] d);
		i_host_master_model.access(w, a0, d, rd);
	endtask : hw
	task automatic wait_call(input logic [11:0] v);
		int n;
		n = 0;
		while (call !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 20)
		begin
			error_cnt++;
			report_and_stop();
		end
		else
			check({vec, ppc, ppsw}, {v, 12'h123, 4'hA});
	endtask : wait_call
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		// A broken disable would take the row writes below as interrupts
		do_op(OP_BUF_IRQ_ON, 8'h00);
		do_op(OP_BUF_IRQ_OFF, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			hw(1'b1, rows[i].a0, rows[i].d);
			hw(1'b0, 1'b1, 8'h00);
			check(rd, rows[i].st);
			do_op(OP_READ_INBUF, 8'h00);
			#1 check({ibv, ib}, {1'b1, rows[i].d});
		end
		do_op(OP_LOAD_COUNT, 8'hFF);
		do_op(OP_OVF_IRQ_ON, 8'h00);
		do_op(OP_BEGIN_COUNT, 8'h00);
		s1 <= 1'b1;
		// Writes above left a request pending while disabled
		do_op(OP_BUF_IRQ_ON, 8'h00);
		wait_call(12'h003);
		@(posedge clk);
		s1 <= 1'b0;
		// Host write during service must stay latched until return
		hw(1'b1, 1'b0, 8'h11);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			#1 check(call, 1'b0);
		end
		check(cnt, 8'h00);
		do_op(OP_RETURN_RESTORE, 8'h00);
		#1 check({rst, spd, rpc, rpsw}, {2'b11, 12'h456, 4'h5});
		wait_call(12'h003);
		do_op(OP_RETURN_RESTORE, 8'h00);
		wait_call(12'h007);
		do_op(OP_RETURN_RESTORE, 8'h00);
		do_op(OP_READ_INBUF, 8'h00);
		#1 check({ibv, ib}, {1'b1, 8'h11});
		do_op(OP_HALT_COUNT, 8'h00);
		s0 <= 1'b1;
		s1 <= 1'b1;
		repeat (6) @(posedge clk);
		check({s0o, s1o}, 2'b11);
		s1 <= 1'b0;
		repeat (6) @(posedge clk);
		check(cnt, 8'h00);
		do_op(OP_HOST_FLAGS, 8'h00);
		repeat (2) @(posedge clk);
		check(p2oe[5:4], 2'b10);
		do_op(OP_WRITE_OUTBUF, 8'h3C);
		repeat (2) @(posedge clk);
		check(p2oe[4], 1'b1);
		hw(1'b0, 1'b0, 8'h00);
		// Flag clears after the read ends, the pin one edge later
		repeat (2) @(posedge clk);
		#1 check({rd, p2oe[4]}, {8'h3C, 1'b0});
		@(posedge clk);
		p2w <= 1'b1;
		acc <= 8'h50;
		@(posedge clk);
		p2w <= 1'b0;
		repeat (2) @(posedge clk);
		check(p2oe[5], 1'b0);
		for (int i = 0; i < 17; i++)
			hw(1'b1, 1'b0, i[7:0]);
		check(wrdy, 1'b0);
		for (int i = 0; i < 16; i++)
		begin
			do_op(OP_READ_INBUF, 8'h00);
			#1 check({ibv, ib}, {1'b1, i[7:0]});
		end
		// Drained: a further read must not claim data
		do_op(OP_READ_INBUF, 8'h00);
		#1 check(ibv, 1'b0);
		do_op(OP_XFER_HS, 8'h00);
		do_op(OP_SET_STATUS, 8'h90);
		i_host_master_model.dma_write(8'h77);
		hw(1'b0, 1'b1, 8'h00);
		check({rd, p2oe[7:6]}, {8'h92, 2'b11});
		do_op(OP_LOAD_COUNT, 8'h55);
		nrst <= 1'b0;
		@(posedge clk);
		#1 check({call, p2oe, hoe, cnt}, {5'h0F, 1'b1, 8'h00});
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		hw(1'b0, 1'b1, 8'h00);
		check({rd, p2oe}, {8'h00, 4'hF});
		report_and_stop();
	end
endmodule : slave_cpu_interrupt_host_port_test
